// >>> dv/multiplexed_programmable_io_port_bench.sv
// Self-checking bench for the programmable pin port
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) begin n_compared++; if ((got) !== (exp)) begin n_mismatch++; \
  $display("Error at %0t: got %h expected %h", $time, (got), (exp)); end end
module multiplexed_programmable_io_port_bench;
  import pio_pkg::*;
  logic        core_clk = 1'b0;
  logic        rst_b    = 1'b0;
  logic [7:0]  awaddr   = 8'h00;
  logic [7:0]  araddr   = 8'h00;
  logic [31:0] wdata    = 32'h0;
  logic        awvalid  = 1'b0;
  logic        wvalid   = 1'b0;
  logic        bready   = 1'b0;
  logic        arvalid  = 1'b0;
  logic        rready   = 1'b0;
  logic        ext_en   = 1'b0;
  logic [15:0] ext      = 16'hffff;
  logic [15:0] pout     = 16'h0000;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [1:0]  bresp, rresp, r;
  logic [31:0] rdata, d;
  logic [15:0] pio_in, pio_out, pio_oe, periph_in;
  logic [15:0] dir_m, func_m, data_m, nd, nf, w, g;
  int          n_mismatch = 0;
  int          n_compared = 0;

  always #20 core_clk = ~core_clk;

  pio_port u_pio_port (.CORE_CLK(core_clk), .RST_B(rst_b), .AWADDR(awaddr),
    .AWVALID(awvalid), .AWREADY(awready), .WDATA(wdata), .WSTRB(4'hf), .WVALID(wvalid),
    .WREADY(wready), .BRESP(bresp), .BVALID(bvalid), .BREADY(bready), .ARADDR(araddr),
    .ARVALID(arvalid), .ARREADY(arready), .RDATA(rdata), .RRESP(rresp), .RVALID(rvalid),
    .RREADY(rready), .PIO_IN(pio_in), .PIO_OUT(pio_out), .PIO_OE(pio_oe),
    .PERIPH_OUT(pout), .PERIPH_IN(periph_in));

  pio_ext_model u_pio_ext_model (.pin_out(pio_out), .pin_oe(pio_oe), .ext_val(ext),
    .ext_en(ext_en), .pin_level(pio_in));

  // Expected pin levels from direction, function, data, peripheral and device
  function automatic logic [15:0] pins_f(input logic [15:0] dr, fn, dt, po, ex);
    return (dr & ((fn & po) | (~fn & dt))) | (~dr & ex);
  endfunction : pins_f

  task automatic axi_wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] rs);
    int n;
    n = 0;
    @(posedge core_clk);
    awaddr  <= a;
    wdata   <= v;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    do begin
      @(posedge core_clk);
      n++;
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (!bvalid && n < 100);
    if (bvalid !== 1'b1) n_mismatch++;
    rs = bresp;
    bready <= 1'b0;
  endtask : axi_wr

  task automatic axi_rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
    int n;
    n = 0;
    @(posedge core_clk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do begin
      @(posedge core_clk);
      n++;
      if (arvalid && arready) arvalid <= 1'b0;
    end while (!rvalid && n < 100);
    if (rvalid !== 1'b1) n_mismatch++;
    v = rdata;
    rs = rresp;
    rready <= 1'b0;
  endtask : axi_rd

  // Wait out the pin sampling chain, then track captured data bits
  task automatic settle();
    repeat (8) @(posedge core_clk);
    g = dir_m & ~func_m;
    data_m = (g & data_m) | (~g & pins_f(dir_m, func_m, data_m, pout, ext));
  endtask : settle

  task automatic check_all();
    logic [15:0] p;
    p = pins_f(dir_m, func_m, data_m, pout, ext);
    `CHK(pio_oe, dir_m)
    `CHK(pio_out & dir_m, p & dir_m)
    `CHK(periph_in, (func_m & p) | ~func_m)
    axi_rd(OFS_DATA, d, r);
    `CHK(d[15:0], data_m)
    axi_rd(OFS_PINS, d, r);
    `CHK(d[15:0], p)
    axi_rd(OFS_DIR, d, r);
    `CHK(d[15:0], dir_m)
    axi_rd(OFS_FUNC, d, r);
    `CHK(d[15:0], func_m)
  endtask : check_all

  task automatic finish_test();
    $display("Compared %0d, mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : finish_test

  initial begin
    #(40 * 20000);
    n_mismatch++;
    finish_test();
  end

  initial begin
    void'($urandom(93174));
    dir_m  = DIR_RESET;
    func_m = FUNC_RESET;
    data_m = DATA_RESET;
    repeat (10) @(posedge core_clk);
    rst_b <= 1'b1;
    settle();
    check_all();
    axi_rd(8'h20, d, r);
    `CHK({r, d}, {RESP_SLVERR, 32'h0})
    axi_wr(8'h24, $urandom, r);
    `CHK(r, RESP_SLVERR)
    axi_wr(OFS_PINS, 32'h0, r);
    `CHK(r, RESP_OKAY)
    ext_en <= 1'b1;
    ext    <= 16'($urandom);
    axi_wr(OFS_DIR, 32'h0, r);
    dir_m = 16'h0;
    settle();
    check_all();
    for (int i = 0; i < 12; i++) begin
      nd = (i == 0) ? 16'hffff : (i == 1) ? 16'h0000 : 16'($urandom);
      nf = (i < 2) ? 16'h0000 : 16'($urandom);
      w  = 16'($urandom);
      ext  <= 16'($urandom);
      pout <= 16'($urandom);
      axi_wr(OFS_SYNC, {30'h0, 2'(i)}, r);
      axi_wr(OFS_DIR, 32'h0, r);
      dir_m = 16'h0;
      settle();
      axi_wr(OFS_FUNC, {16'h0, nf}, r);
      func_m = nf;
      settle();
      axi_wr(OFS_DIR, {16'h0, nd}, r);
      dir_m = nd;
      `CHK(pio_out & nd, pins_f(nd, nf, data_m, pout, ext) & nd)
      settle();
      axi_wr(OFS_DATA, {16'h0, w}, r);
      `CHK(r, RESP_OKAY)
      g = dir_m & ~func_m;
      data_m = (g & w) | (~g & data_m);
      settle();
      check_all();
      axi_rd(OFS_SYNC, d, r);
      `CHK(d[1:0], 2'(i))
    end
    finish_test();
  end
endmodule : multiplexed_programmable_io_port_bench
`default_nettype wire

// >>> dv/pio_ext_model.sv
// External devices and pull-ups seen on the sixteen port pins
`timescale 1ns/1ps
`default_nettype none
module pio_ext_model
  import pio_pkg::*;
(
  input  wire logic [PIN_COUNT-1:0] pin_out,
  input  wire logic [PIN_COUNT-1:0] pin_oe,
  input  wire logic [PIN_COUNT-1:0] ext_val,
  input  wire logic                 ext_en,
  output var  logic [PIN_COUNT-1:0] pin_level
);
  // Driven pins follow the port; released pins follow the device or the pull-up
  always_comb begin
    for (int i = 0; i < PIN_COUNT; i++) begin
      pin_level[i] = pin_oe[i] ? pin_out[i] : (ext_en ? ext_val[i] : 1'b1);
    end
  end
endmodule : pio_ext_model
`default_nettype wire

// >>> rtl/pio_pin_mux.sv
// Per-pin steering of driver source, enable and peripheral input
`timescale 1ns/1ps
`default_nettype none
module pio_pin_mux #(
  parameter int WIDTH = 16
) (
  input  wire logic [WIDTH-1:0] dir,
  input  wire logic [WIDTH-1:0] func,
  input  wire logic [WIDTH-1:0] data,
  input  wire logic [WIDTH-1:0] periph_out,
  input  wire logic [WIDTH-1:0] pin_s,
  output var  logic [WIDTH-1:0] pin_out,
  output var  logic [WIDTH-1:0] pin_oe,
  output var  logic [WIDTH-1:0] periph_in
);
  always_comb begin
    pin_out   = (func & periph_out) | (~func & data);
    pin_oe    = dir;
    periph_in = (func & pin_s) | ~func;
  end
endmodule : pio_pin_mux
`default_nettype wire

// >>> rtl/pio_pkg.sv
// Constants shared by the programmable pin port
package pio_pkg;
  localparam int          PIN_COUNT   = 16;
  localparam int          GROUP_COUNT = 2;
  localparam int          GROUP_WIDTH = 8;
  localparam int          ADDR_W      = 8;
  localparam int          SYNC_STAGES = 2;
  localparam logic [7:0]  OFS_DATA    = 8'h00;
  localparam logic [7:0]  OFS_DIR     = 8'h04;
  localparam logic [7:0]  OFS_FUNC    = 8'h08;
  localparam logic [7:0]  OFS_SYNC    = 8'h0c;
  localparam logic [7:0]  OFS_PINS    = 8'h10;
  localparam logic [15:0] DATA_RESET  = 16'h0000;
  localparam logic [15:0] FUNC_RESET  = 16'hffff;
  localparam logic [15:0] DIR_RESET   = 16'h8000;
  localparam logic [1:0]  SYNC_RESET  = 2'h0;
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;
endpackage : pio_pkg

// >>> rtl/pio_port.sv
// Sixteen-pin programmable I/O port with AXI4-Lite register access
// Contract
// [R01] Sixteen pins, each independently shared between a peripheral and software use.
// [R02] General purpose output pins drive the software data bit at any time.
// [R03] Input direction pins are readable by software through the data register.
// [R04] Most pins reset to input; a few reset to output for their peripheral. DIR_RESET makes only pin 15 an output.
// [R05] General purpose selection forces the peripheral input to its de-asserted level.
// [R06] Data writes only change bits that are general purpose outputs.
// [R07] Input to output switch first drives data captured one clock earlier.
// [R08] Software sets input, then function, then final direction, then uses data.
// [R09] Function select resets to peripheral mode.
// [R10] Peripheral function with output direction lets the peripheral drive the pin.
// [R11] General output setup: select general purpose, set output, then write data.
// [R12] General input setup: select general purpose, set input if needed, read.
// [R13] Peripheral input on an output-default pin: set input, keep function mode.
// [R14] One data write updates all outputs; one read returns all inputs.
// [R15] Input level always reaches data; peripheral sees it only in function mode.
// [R16] Output source is the peripheral in function mode, else the data bit.
// [R17] Data bits capture pins when in input direction or function mode.
// [R18] Group synchronization option adds double register sampling on the clock.
// [R19] Direction, function and data are separate per-pin registers; data resets zero.
`timescale 1ns/1ps
`default_nettype none
module pio_port
  import pio_pkg::*;
#(
  parameter logic [PIN_COUNT-1:0] DIR_INIT = DIR_RESET
) (
  input  wire logic                 CORE_CLK,
  input  wire logic                 RST_B,
  input  wire logic [ADDR_W-1:0]    AWADDR,
  input  wire logic                 AWVALID,
  output var  logic                 AWREADY,
  input  wire logic [31:0]          WDATA,
  input  wire logic [3:0]           WSTRB,
  input  wire logic                 WVALID,
  output var  logic                 WREADY,
  output var  logic [1:0]           BRESP,
  output var  logic                 BVALID,
  input  wire logic                 BREADY,
  input  wire logic [ADDR_W-1:0]    ARADDR,
  input  wire logic                 ARVALID,
  output var  logic                 ARREADY,
  output var  logic [31:0]          RDATA,
  output var  logic [1:0]           RRESP,
  output var  logic                 RVALID,
  input  wire logic                 RREADY,
  input  wire logic [PIN_COUNT-1:0] PIO_IN,
  output var  logic [PIN_COUNT-1:0] PIO_OUT,
  output var  logic [PIN_COUNT-1:0] PIO_OE,
  input  wire logic [PIN_COUNT-1:0] PERIPH_OUT,
  output var  logic [PIN_COUNT-1:0] PERIPH_IN
);
  logic [PIN_COUNT-1:0]   data_reg;
  logic [PIN_COUNT-1:0]   data_next;
  logic [PIN_COUNT-1:0]   dir_reg;
  logic [PIN_COUNT-1:0]   func_reg;
  logic [GROUP_COUNT-1:0] sync_reg;
  logic [PIN_COUNT-1:0]   pin_a;
  logic [PIN_COUNT-1:0]   pin_b;
  logic [PIN_COUNT-1:0]   pin_s;
  logic [PIN_COUNT-1:0]   grp_mask;
  logic [PIN_COUNT-1:0]   wr_mask;
  logic [PIN_COUNT-1:0]   cap_mask;
  logic [PIN_COUNT-1:0]   merged;
  logic                   aw_held_reg;
  logic                   w_held_reg;
  logic [ADDR_W-1:0]      aw_addr_reg;
  logic [31:0]            w_data_reg;
  logic [3:0]             w_strb_reg;
  logic                   bvalid_reg;
  logic [1:0]             bresp_reg;
  logic                   rvalid_reg;
  logic [1:0]             rresp_reg;
  logic [31:0]            rdata_reg;
  logic                   do_write;
  logic [ADDR_W-1:0]      wr_addr;
  logic                   wr_data_hit;

  function automatic logic [PIN_COUNT-1:0] merge_word(
    input logic [PIN_COUNT-1:0] old_val,
    input logic [31:0]          wdata,
    input logic [3:0]           strb
  );
    logic [PIN_COUNT-1:0] res;
    res = old_val;
    for (int b = 0; b < PIN_COUNT / 8; b++) begin
      if (strb[b]) begin
        res[b*8 +: 8] = wdata[b*8 +: 8];
      end
    end
    return res;
  endfunction : merge_word

  function automatic logic [ADDR_W-1:0] word_addr(input logic [ADDR_W-1:0] a);
    return {a[ADDR_W-1:2], 2'b00};
  endfunction : word_addr

  // Pin sampling, with optional extra double register per group
  pio_sync #(.WIDTH(PIN_COUNT), .STAGES(SYNC_STAGES)) u_sync_pin (
    .clk   (CORE_CLK),
    .rst_b (RST_B),
    .d     (PIO_IN),
    .q     (pin_a)
  );

  pio_sync #(.WIDTH(PIN_COUNT), .STAGES(SYNC_STAGES)) u_sync_grp (
    .clk   (CORE_CLK),
    .rst_b (RST_B),
    .d     (pin_a),
    .q     (pin_b)
  );

  always_comb begin
    for (int g = 0; g < GROUP_COUNT; g++) begin
      grp_mask[g*GROUP_WIDTH +: GROUP_WIDTH] = {GROUP_WIDTH{sync_reg[g]}};
    end
    pin_s = (grp_mask & pin_b) | (~grp_mask & pin_a); // [R18]
  end

  // Pin driver and peripheral input steering
  pio_pin_mux #(.WIDTH(PIN_COUNT)) u_mux (
    .dir        (dir_reg),
    .func       (func_reg),
    .data       (data_reg),
    .periph_out (PERIPH_OUT),
    .pin_s      (pin_s),
    .pin_out    (PIO_OUT),   // [R02] [R16] [R01]
    .pin_oe     (PIO_OE),    // [R10]
    .periph_in  (PERIPH_IN)  // [R05] [R15]
  );

  // Write channel
  assign AWREADY  = !aw_held_reg;
  assign WREADY   = !w_held_reg;
  assign do_write = aw_held_reg && w_held_reg && !bvalid_reg;
  assign wr_addr  = word_addr(aw_addr_reg);
  assign BVALID   = bvalid_reg;
  assign BRESP    = bresp_reg;

  always_ff @(posedge CORE_CLK or negedge RST_B) begin
    if (!RST_B) begin
      aw_held_reg <= 1'b0;
      aw_addr_reg <= '0;
    end else if (AWVALID && AWREADY) begin
      aw_held_reg <= 1'b1;
      aw_addr_reg <= AWADDR;
    end else if (do_write) begin
      aw_held_reg <= 1'b0;
    end
  end

  always_ff @(posedge CORE_CLK or negedge RST_B) begin
    if (!RST_B) begin
      w_held_reg <= 1'b0;
      w_data_reg <= '0;
      w_strb_reg <= '0;
    end else if (WVALID && WREADY) begin
      w_held_reg <= 1'b1;
      w_data_reg <= WDATA;
      w_strb_reg <= WSTRB;
    end else if (do_write) begin
      w_held_reg <= 1'b0;
    end
  end

  always_ff @(posedge CORE_CLK or negedge RST_B) begin
    if (!RST_B) begin
      bvalid_reg <= 1'b0;
      bresp_reg  <= RESP_OKAY;
    end else if (do_write) begin
      bvalid_reg <= 1'b1;
      unique case (wr_addr)
        OFS_DATA, OFS_DIR, OFS_FUNC, OFS_SYNC, OFS_PINS: bresp_reg <= RESP_OKAY;
        default: bresp_reg <= RESP_SLVERR;
      endcase
    end else if (bvalid_reg && BREADY) begin
      bvalid_reg <= 1'b0;
    end
  end

  // Control registers
  always_ff @(posedge CORE_CLK or negedge RST_B) begin
    if (!RST_B) begin
      dir_reg <= DIR_INIT; // [R04] [R10]
    end else if (do_write && wr_addr == OFS_DIR) begin
      dir_reg <= merge_word(dir_reg, w_data_reg, w_strb_reg); // [R19]
    end
  end

  always_ff @(posedge CORE_CLK or negedge RST_B) begin
    if (!RST_B) begin
      func_reg <= FUNC_RESET; // [R09]
    end else if (do_write && wr_addr == OFS_FUNC) begin
      func_reg <= merge_word(func_reg, w_data_reg, w_strb_reg); // [R19]
    end
  end

  always_ff @(posedge CORE_CLK or negedge RST_B) begin
    if (!RST_B) begin
      sync_reg <= SYNC_RESET;
    end else if (do_write && wr_addr == OFS_SYNC) begin
      if (w_strb_reg[0]) begin
        sync_reg <= w_data_reg[GROUP_COUNT-1:0]; // [R18]
      end
    end
  end

  // Data register: capture and masked software write
  assign wr_mask     = dir_reg & ~func_reg;  // [R06]
  assign cap_mask    = ~dir_reg | func_reg;  // [R17]
  assign wr_data_hit = do_write && wr_addr == OFS_DATA;
  assign merged      = merge_word(data_reg, w_data_reg, w_strb_reg);

  always_comb begin
    data_next = (data_reg & ~cap_mask) | (pin_s & cap_mask); // [R17] [R03]
    if (wr_data_hit) begin
      data_next = (data_next & ~wr_mask) | (merged & wr_mask); // [R06] [R14]
    end
  end

  always_ff @(posedge CORE_CLK or negedge RST_B) begin
    if (!RST_B) begin
      data_reg <= DATA_RESET; // [R19]
    end else begin
      data_reg <= data_next; // [R07]
    end
  end

  // Read channel
  assign ARREADY = !rvalid_reg;
  assign RVALID  = rvalid_reg;
  assign RDATA   = rdata_reg;
  assign RRESP   = rresp_reg;

  always_ff @(posedge CORE_CLK or negedge RST_B) begin
    if (!RST_B) begin
      rvalid_reg <= 1'b0;
      rdata_reg  <= '0;
      rresp_reg  <= RESP_OKAY;
    end else if (ARVALID && ARREADY) begin
      rvalid_reg <= 1'b1;
      rresp_reg  <= RESP_OKAY;
      unique case (word_addr(ARADDR))
        OFS_DATA: rdata_reg <= {16'h0000, data_reg}; // [R03] [R14]
        OFS_DIR:  rdata_reg <= {16'h0000, dir_reg};
        OFS_FUNC: rdata_reg <= {16'h0000, func_reg};
        OFS_SYNC: rdata_reg <= {30'h0000_0000, sync_reg};
        OFS_PINS: rdata_reg <= {16'h0000, pin_s};
        default: begin
          rdata_reg <= '0;
          rresp_reg <= RESP_SLVERR;
        end
      endcase
    end else if (rvalid_reg && RREADY) begin
      rvalid_reg <= 1'b0;
    end
  end

  // Checks
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (!RST_B);

  // Cycles since reset, until the sampling chain holds real pin history
  localparam int SETTLE = 2 * SYNC_STAGES;
  logic [2:0] settle_reg;

  always_ff @(posedge CORE_CLK or negedge RST_B) begin
    if (!RST_B) begin
      settle_reg <= '0;
    end else if (settle_reg != 3'(SETTLE)) begin
      settle_reg <= settle_reg + 3'h1;
    end
  end

  sequence s_both_held;
    aw_held_reg && w_held_reg && !bvalid_reg;
  endsequence

  sequence s_resp_wait;
    bvalid_reg && !BREADY;
  endsequence

  sequence s_dir_rise_gp;
    |(dir_reg & ~$past(dir_reg) & ~func_reg);
  endsequence

  AST_WR_RESP: assert property (s_both_held |=> BVALID && AWREADY ##0 WREADY)
    else $error("write response missing after both halves held");
  AST_BHOLD: assert property (s_resp_wait |=> BVALID && $stable(BRESP))
    else $error("write response dropped before being taken");
  AST_RLAT: assert property (ARVALID && ARREADY |=> RVALID ##0 !ARREADY)
    else $error("read data not presented one cycle after address");
  AST_RHOLD: assert property (RVALID && !RREADY |=> RVALID && $stable(RDATA))
    else $error("read data changed before being taken");
  AST_WR_MASK: assert property (wr_data_hit |=> // [R06]
    ((data_reg ^ $past(pin_s)) & $past(~wr_mask)) == '0)
    else $error("protected data bit changed by a write");
  AST_WR_ALL: assert property (wr_data_hit |=> // [R14]
    ((data_reg ^ $past(merged)) & $past(wr_mask)) == '0)
    else $error("general output bit missed a data write");
  AST_GP_OUT: assert property (((PIO_OUT ^ data_reg) & dir_reg & ~func_reg) == '0) // [R02]
    else $error("general output pin not driven from data bit");
  AST_FN_OUT: assert property (((PIO_OUT ^ PERIPH_OUT) & func_reg) == '0) // [R16]
    else $error("function pin not driven by peripheral");
  AST_OE: assert property (PIO_OE == dir_reg) // [R10]
    else $error("pin enable does not follow direction");
  AST_PERIPH_IN: assert property (((~func_reg & ~PERIPH_IN) | // [R05]
    ((PERIPH_IN ^ pin_s) & func_reg)) == '0)
    else $error("peripheral input not steered correctly");
  AST_CAPTURE: assert property (!$past(wr_data_hit) |-> // [R17]
    ((data_reg ^ $past(pin_s)) & $past(cap_mask)) == '0)
    else $error("data bit failed to capture pin level");
  AST_SWITCH: assert property (s_dir_rise_gp |-> // [R07]
    ((PIO_OUT ^ $past(pin_s)) & dir_reg & ~$past(dir_reg) & ~func_reg) == '0)
    else $error("output after switch is not the prior captured level");
  AST_SYNC: assert property (settle_reg == 3'(SETTLE) && sync_reg == $past(sync_reg, 4) |-> // [R18]
    pin_s == ((grp_mask & $past(PIO_IN, 4)) | (~grp_mask & $past(PIO_IN, 2))))
    else $error("pin sampling depth does not match group option");
endmodule : pio_port
`default_nettype wire

// >>> rtl/pio_sync.sv
// Chain of sampling flip-flops for a bus of pin levels
`timescale 1ns/1ps
`default_nettype none
module pio_sync #(
  parameter int WIDTH  = 16,
  parameter int STAGES = 2
) (
  input  wire logic             clk,
  input  wire logic             rst_b,
  input  wire logic [WIDTH-1:0] d,
  output var  logic [WIDTH-1:0] q
);
  logic [WIDTH-1:0] stage_reg [STAGES];

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      for (int i = 0; i < STAGES; i++) begin
        stage_reg[i] <= '0;
      end
    end else begin
      stage_reg[0] <= d;
      for (int i = 1; i < STAGES; i++) begin
        stage_reg[i] <= stage_reg[i-1];
      end
    end
  end

  assign q = stage_reg[STAGES-1];
endmodule : pio_sync
`default_nettype wire
